// file: inc/acx_pkg.sv
// constants and types for the accumulator instruction executor
// Notes on behaviour
// - each indirect level adds one machine cycle to the instruction.
// - load_word replaces accumulator from memory, program counter advances, one cycle.
// - jump_direct moves control to the address, accumulator untouched, one cycle.
// - jump_save_return stores pc+1 via A, continues at A+1, clears accumulator.
// - add takes two cycles and sets overflow, held until add, index, clear or interrupt_return.
// - logical and merges memory word into accumulator in two cycles.
// - store_accumulator writes the accumulator to memory in two cycles.
// - increment_skip_zero increments memory, copies to accumulator, skips on zero.
// - shift_left shifts accumulator left by count, zero filled, one cycle.
// - rotate_left rotates accumulator left, top bits reenter at bottom.
// - stop_execution halts; run resumes continuously, single cycle advances one.
// - skip_if_zero and skip_if_nonzero test the accumulator for zero.
// - skip_if_bit_set skips on accumulator bit B, bit 0 most significant.
// - skip_if_no_overflow skips when the overflow indicator is clear.
// - negate_accumulator replaces accumulator with its two's complement.
// - data_output_instr drives accumulator, address, function, then output_strobe if running or stepped before STB_POS.
// - data input sends address, captures bus word on the same edge that drops input_strobe.
// - interrupt_return restores pc, accumulator, overflow of level L, four cycles.
// - interrupt_mask_instr blocks servicing; pending interrupts wait for unmask.
// - interrupt_unmask_instr restores normal servicing in one cycle.
// - instruction word is indirect bit, three-bit operation_code, twelve-bit address.
// - accumulator arithmetic is two's complement.
// - sense status lets software test whether a device is ready.
package acx_pkg;
    localparam int ACX_DW = 16;
    localparam int ACX_AW = 15;
    // instruction fields
    localparam int IND_BIT = 15;
    localparam int OP_LSB = 12;
    localparam int SUB_LSB = 8;
    localparam int DEV_LSB = 4;
    // timing: one machine cycle spans several system clocks
    localparam int CLK_PERIOD_NS = 8;
    localparam int MACHINE_CYCLE_NS = 32;
    localparam int CYC_CLKS = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
    localparam int STB_POS = 1;
    // reset values and vectors
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [15:0] ACC_RST = 16'h0000;
    localparam logic [14:0] VEC_BASE = 15'h0010;
    // register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PC = 12'h008;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STEP = 1;
    localparam int CTRL_STOP = 2;

    typedef enum logic [2:0] {
        OP_LOAD = 3'h0, OP_JUMP = 3'h1, OP_JSR = 3'h2, OP_ADD = 3'h3,
        OP_AND = 3'h4, OP_STORE = 3'h5, OP_INCSKIP = 3'h6, OP_GROUP = 3'h7
    } acx_op_t;

    typedef enum logic [3:0] {
        SUB_SHL = 4'h0, SUB_ROL = 4'h1, SUB_STOP = 4'h2, SUB_SKZ = 4'h3,
        SUB_SKNZ = 4'h4, SUB_SKBIT = 4'h5, SUB_SKNOV = 4'h6, SUB_NEG = 4'h7,
        SUB_DOUT = 4'h8, SUB_DIN = 4'h9, SUB_IRET = 4'ha, SUB_MASK = 4'hb,
        SUB_UNMASK = 4'hc, SUB_SENSE = 4'hd, SUB_CLEAR = 4'he,
        SUB_NOP = 4'hf
    } acx_sub_t;

    typedef enum logic [2:0] {
        S_FETCH = 3'b000, S_IND = 3'b001, S_EX1 = 3'b011, S_EX2 = 3'b010,
        S_EX3 = 3'b110, S_EX4 = 3'b111, S_IRQ = 3'b101
    } acx_state_t;
endpackage : acx_pkg

// file: rtl/acx_core.sv
// accumulator cpu executor with apb control and parallel i/o bus
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module acx_core
    import acx_pkg::*;
#(
    parameter int NLEV = 4,
    parameter int CYC = CYC_CLKS
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // program memory
    output logic [14:0] o_mem_addr,
    output logic o_mem_we,
    output logic [15:0] o_mem_wdata,
    input wire logic [15:0] i_mem_rdata,
    // parallel i/o bus
    output logic [3:0] o_io_addr,
    output logic [3:0] o_io_func,
    output logic [15:0] o_io_data,
    output logic o_io_data_oe,
    input wire logic [15:0] i_io_data,
    output logic o_output_strobe,
    output logic o_input_strobe,
    input wire logic [15:0] i_sense,
    // interrupt requests
    input wire logic [NLEV-1:0] i_irq
);
    localparam int LW = (NLEV > 1) ? $clog2(NLEV) : 1;
    localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;

    acx_state_t state, next_state;
    logic [CW-1:0] cyc_cnt;
    logic cyc_en, adv, running, step_req, masked, ovf;
    logic [15:0] acc, ir, tmp;
    logic [14:0] pc, ea;
    logic [15:0] io_s1, io_s2, sense_s1, sense_s2;
    logic [NLEV-1:0] irq_s1, irq_s2, irq_s3, pend, active;
    logic [14:0] sv_pc [NLEV];
    logic [15:0] sv_acc [NLEV];
    logic [NLEV-1:0] sv_ovf;

    ////////////////////////////////////////////////////////////////////
    // machine cycle divider and run control
    assign cyc_en = (cyc_cnt == CW'(CYC - 1));
    assign adv = cyc_en && (running || step_req);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || cyc_en) begin
            cyc_cnt <= '0;
        end else begin
            cyc_cnt <= cyc_cnt + CW'(1);
        end
    end

    logic wr_ctrl, wr_pc, hit, stop_now;
    assign hit = (i_paddr == REG_CTRL) || (i_paddr == REG_STATUS) ||
                 (i_paddr == REG_PC);
    assign wr_ctrl = i_psel && i_penable && i_pwrite && i_paddr == REG_CTRL;
    assign wr_pc = i_psel && i_penable && i_pwrite && i_paddr == REG_PC;

    // run wins over a stop in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            running <= 1'b0;
        end else if (wr_ctrl && i_pwdata[CTRL_RUN]) begin
            running <= 1'b1;
        end else if ((adv && stop_now) || (wr_ctrl && i_pwdata[CTRL_STOP])) begin
            running <= 1'b0;
        end
    end

    // single cycle grant, consumed by one machine cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            step_req <= 1'b0;
        end else if (wr_ctrl && i_pwdata[CTRL_STEP]) begin
            step_req <= 1'b1;
        end else if (cyc_en && !running) begin
            step_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave: zero wait, read data captured in the setup cycle
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = o_pready && !hit;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_prdata <= '0;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                REG_CTRL: o_prdata <= {30'h0, step_req, running};
                REG_STATUS: o_prdata <= {13'h0, running, masked, ovf, acc};
                REG_PC: o_prdata <= {17'h0, pc};
                default: o_prdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge i_clk_sys) begin
        io_s1 <= i_io_data;
        io_s2 <= io_s1;
        sense_s1 <= i_sense;
        sense_s2 <= sense_s1;
        irq_s1 <= i_irq;
        irq_s2 <= irq_s1;
        irq_s3 <= irq_s2;
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt bookkeeping
    logic irq_take, irq_enter, inr_done;
    logic [LW-1:0] irq_lvl, ret_lvl;

    always_comb begin
        irq_lvl = '0;
        for (int i = NLEV - 1; i >= 0; i--) begin
            if (pend[i]) begin
                irq_lvl = LW'(i);
            end
        end
    end

    // masked requests stay pending until unmasked
    assign irq_take = !masked && (|pend) && !(|active);
    assign ret_lvl = ir[LW-1:0];

    // new edges win over the clear of the level being entered
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~(irq_enter ? (NLEV'(1) << irq_lvl) : '0)) |
                    (irq_s2 & ~irq_s3);
        end
    end

    // level returns to idle on interrupt return
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            active <= '0;
        end else if (irq_enter) begin
            active[irq_lvl] <= 1'b1;
        end else if (inr_done) begin
            active[ret_lvl] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (irq_enter) begin
            sv_pc[irq_lvl] <= pc;
            sv_acc[irq_lvl] <= acc;
            sv_ovf[irq_lvl] <= ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // instruction sequencing
    acx_op_t op, nop;
    acx_sub_t sub, nsub;
    logic [15:0] next_acc, next_ir, next_tmp, sum, next_wdata;
    logic [14:0] next_pc, next_ea, next_addr;
    logic [31:0] rot2;
    logic next_ovf, next_mask, next_we, done;

    assign op = acx_op_t'(ir[14:OP_LSB]);
    assign sub = acx_sub_t'(ir[11:SUB_LSB]);
    assign sum = acc + tmp;
    assign rot2 = {acc, acc} << ir[3:0];

    always_comb begin
        next_state = state;
        next_pc = pc;
        next_acc = acc;
        next_ovf = ovf;
        next_ea = ea;
        next_tmp = tmp;
        next_ir = ir;
        next_mask = masked;
        next_addr = o_mem_addr;
        next_we = 1'b0;
        next_wdata = o_mem_wdata;
        done = 1'b0;
        stop_now = 1'b0;
        irq_enter = 1'b0;
        inr_done = 1'b0;
        case (state)
            S_FETCH: begin
                next_ir = i_mem_rdata;
                next_pc = pc + 15'h1;
                next_ea = {3'h0, i_mem_rdata[11:0]};
                if (i_mem_rdata[14:OP_LSB] != OP_GROUP && i_mem_rdata[IND_BIT])
                begin
                    next_state = S_IND;
                end else begin
                    next_state = S_EX1;
                end
            end
            S_IND: begin
                next_ea = i_mem_rdata[14:0];
                if (!i_mem_rdata[IND_BIT]) begin
                    next_state = S_EX1;
                end
            end
            S_EX1: begin
                next_state = S_EX2;
                case (op)
                    OP_LOAD: begin
                        next_acc = i_mem_rdata;
                        done = 1'b1;
                    end
                    OP_JUMP: begin
                        next_pc = ea;
                        done = 1'b1;
                    end
                    OP_JSR, OP_ADD, OP_AND: next_tmp = i_mem_rdata;
                    OP_INCSKIP: next_tmp = i_mem_rdata + 16'h1;
                    OP_STORE: next_tmp = tmp;
                    default: begin
                        done = (sub != SUB_IRET);
                        case (sub)
                            // zero filled shift by low field
                            SUB_SHL: next_acc = acc << ir[3:0];
                            SUB_ROL: next_acc = rot2[31:16];
                            SUB_STOP: stop_now = 1'b1;
                            SUB_SKZ: if (acc == 16'h0) next_pc = pc + 15'h1;
                            SUB_SKNZ: if (acc != 16'h0) next_pc = pc + 15'h1;
                            SUB_SKBIT: begin
                                if (acc[4'hf - ir[3:0]]) next_pc = pc + 15'h1;
                            end
                            SUB_SKNOV: if (!ovf) next_pc = pc + 15'h1;
                            SUB_NEG: next_acc = 16'h0 - acc;
                            SUB_DIN: next_acc = io_s2;
                            SUB_MASK: next_mask = 1'b1;
                            SUB_UNMASK: next_mask = 1'b0;
                            SUB_SENSE: begin
                                if (sense_s2[ir[7:DEV_LSB]]) next_pc = pc + 15'h1;
                            end
                            SUB_CLEAR: begin
                                next_acc = 16'h0;
                                next_ovf = 1'b0;
                            end
                            default: next_acc = acc;
                        endcase
                    end
                endcase
            end
            S_EX2: begin
                next_state = S_EX3;
                case (op)
                    OP_ADD: begin
                        next_acc = sum;
                        next_ovf = (acc[15] == tmp[15]) && (sum[15] != acc[15]);
                        done = 1'b1;
                    end
                    OP_AND: begin
                        next_acc = acc & tmp;
                        done = 1'b1;
                    end
                    OP_STORE: done = 1'b1;
                    default: next_state = S_EX3;
                endcase
            end
            S_EX3: begin
                next_state = S_EX4;
                case (op)
                    OP_JSR: begin
                        next_pc = ea + 15'h1;
                        next_acc = 16'h0;
                        done = 1'b1;
                    end
                    // result to accumulator, skip on wrap
                    OP_INCSKIP: begin
                        next_acc = tmp;
                        next_ovf = (tmp == 16'h8000);
                        if (tmp == 16'h0) next_pc = pc + 15'h1;
                        done = 1'b1;
                    end
                    default: next_state = S_EX4;
                endcase
            end
            S_EX4: begin
                // restore the saved context of level L
                next_pc = sv_pc[ret_lvl];
                next_acc = sv_acc[ret_lvl];
                next_ovf = sv_ovf[ret_lvl];
                inr_done = adv;
                done = 1'b1;
            end
            S_IRQ: begin
                irq_enter = adv;
                next_pc = VEC_BASE + 15'(irq_lvl);
                next_state = S_FETCH;
            end
            default: next_state = S_FETCH;
        endcase
        if (done) begin
            next_state = irq_take ? S_IRQ : S_FETCH;
        end
        nop = acx_op_t'(next_ir[14:OP_LSB]);
        case (next_state)
            S_FETCH: next_addr = next_pc;
            S_IND, S_EX1: next_addr = next_ea;
            S_EX2: begin
                // return address through the pointer word
                if (nop == OP_JSR) begin
                    next_addr = next_tmp[14:0];
                    next_we = 1'b1;
                    next_wdata = {1'b0, next_pc};
                end else if (nop == OP_STORE) begin
                    next_addr = ea;
                    next_we = 1'b1;
                    next_wdata = acc;
                end else if (nop == OP_INCSKIP) begin
                    next_addr = ea;
                    next_we = 1'b1;
                    next_wdata = next_tmp;
                end
            end
            default: next_addr = o_mem_addr;
        endcase
    end

    assign nsub = acx_sub_t'(next_ir[11:SUB_LSB]);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= S_FETCH;
            ir <= 16'h0;
            ea <= 15'h0;
            tmp <= 16'h0;
        end else if (adv) begin
            state <= next_state;
            ir <= next_ir;
            ea <= next_ea;
            tmp <= next_tmp;
        end
    end

    // cleared accumulator and overflow, masked, halted
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            acc <= ACC_RST;
            ovf <= 1'b0;
            masked <= 1'b1;
        end else if (adv) begin
            acc <= next_acc;
            ovf <= next_ovf;
            masked <= next_mask;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pc <= PC_RST;
            o_mem_addr <= PC_RST;
            o_mem_we <= 1'b0;
            o_mem_wdata <= 16'h0;
        end else if (adv) begin
            pc <= next_pc;
            o_mem_addr <= next_addr;
            o_mem_we <= next_we;
            o_mem_wdata <= next_wdata;
        end else if (wr_pc && !running && state == S_FETCH) begin
            pc <= i_pwdata[14:0];
            o_mem_addr <= i_pwdata[14:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // i/o bus: fields stand for the whole instruction cycle
    logic io_enter;
    assign io_enter = adv && next_state == S_EX1 && nop == OP_GROUP &&
                      (nsub == SUB_DOUT || nsub == SUB_DIN);

    // address, function and data with the strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_addr <= 4'h0;
            o_io_func <= 4'h0;
            o_io_data <= 16'h0;
            o_io_data_oe <= 1'b0;
            o_input_strobe <= 1'b0;
        end else if (io_enter) begin
            o_io_addr <= next_ir[7:DEV_LSB];
            o_io_func <= next_ir[3:0];
            o_io_data <= acc;
            o_io_data_oe <= (nsub == SUB_DOUT);
            o_input_strobe <= (nsub == SUB_DIN);
        end else if (adv && state == S_EX1) begin
            o_io_data_oe <= 1'b0;
            o_input_strobe <= 1'b0;
        end
    end

    // one strobe pulse while data is stable, if running or stepped before count STB_POS
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_output_strobe <= 1'b0;
        end else begin
            o_output_strobe <= o_io_data_oe && (running || step_req) &&
                               cyc_cnt == CW'(STB_POS);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    AST_IND_CYCLE: assert property (
        adv && state == S_FETCH && i_mem_rdata[IND_BIT] &&
        i_mem_rdata[14:OP_LSB] != OP_GROUP |=> state == S_IND)
        else $error("indirect level did not add a cycle");
    AST_LOAD: assert property (
        adv && state == S_EX1 && op == OP_LOAD |=>
        acc == $past(i_mem_rdata) && pc == $past(pc))
        else $error("load word wrong");
    AST_JUMP: assert property (
        adv && state == S_EX1 && op == OP_JUMP |=>
        pc == $past(ea) && $stable(acc))
        else $error("jump wrong");
    AST_JSR: assert property (
        adv && state == S_EX3 && op == OP_JSR |=>
        acc == 16'h0 && pc == $past(ea) + 15'h1)
        else $error("jump save return wrong");
    AST_ADD: assert property (
        adv && state == S_EX2 && op == OP_ADD |=>
        acc == $past(acc) + $past(tmp))
        else $error("add result wrong");
    AST_STORE: assert property (
        state == S_EX2 && op == OP_STORE |->
        o_mem_we && o_mem_addr == ea && o_mem_wdata == acc)
        else $error("store did not write accumulator");
    AST_SKZ: assert property (
        adv && state == S_EX1 && op == OP_GROUP && sub == SUB_SKZ &&
        acc == 16'h0 |=> pc == $past(pc) + 15'h1)
        else $error("skip on zero missed");
    AST_HALTED: assert property (
        !running && !step_req && !wr_pc |=> $stable(state) && $stable(pc))
        else $error("advanced while halted");
    AST_DOS: assert property (
        o_output_strobe |-> o_io_data_oe ##1 !o_output_strobe)
        else $error("output strobe without data or too long");
    AST_MASKED: assert property (
        masked && adv |=> state != S_IRQ)
        else $error("interrupt taken while masked");

    COV_JSR: cover property (adv && state == S_EX3 && op == OP_JSR);
    COV_IRQ: cover property (irq_enter);
    COV_DIN: cover property (o_input_strobe ##1 !o_input_strobe);
    COV_IRET: cover property (inr_done);
endmodule : acx_core

// file: testbench/acx_periph.sv
// peripheral model on the far side of the parallel i/o bus
`timescale 1ns/1ns
module acx_periph (
    // bus from the executor
    input wire logic i_clk_sys,
    input wire logic [3:0] i_io_addr,
    input wire logic [3:0] i_io_func,
    input wire logic [15:0] i_io_data,
    input wire logic i_io_data_oe,
    input wire logic i_output_strobe,
    input wire logic i_input_strobe,
    // answers to the executor
    output logic [15:0] o_io_data,
    output logic [15:0] o_sense
);
    logic [15:0] latched [16];
    logic [15:0] last = 16'h0;
    assign o_sense = 16'hffff;
    always @(posedge i_clk_sys)
        if (i_output_strobe && i_io_data_oe)
            latched[i_io_addr] <= i_io_data;
    always @(posedge i_clk_sys)
        if (i_input_strobe)
            last <= {8'hd0, i_io_addr, i_io_func};
    // released bus must not keep showing the old word
    assign o_io_data = i_input_strobe ? {8'hd0, i_io_addr, i_io_func} : ~last;
endmodule : acx_periph

// file: testbench/tb_acx_core.sv
// self-checking bench for the accumulator executor
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_acx_core;
    logic i_clk_sys = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwd = 0, prd, st;
    logic [14:0] maddr;
    logic mwe, pready, pslverr, ostb, istb, oe;
    logic [15:0] mwd, iod, pio, sense;
    logic [3:0] ioa, iof;
    logic [3:0] irq = 4'h0;
    logic [15:0] mem [512];
    int num_errors = 0, comparisons = 0;
    acx_core i_acx_core (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready),
        .o_pslverr(pslverr), .o_mem_addr(maddr), .o_mem_we(mwe),
        .o_mem_wdata(mwd), .i_mem_rdata(mem[maddr[8:0]]), .o_io_addr(ioa),
        .o_io_func(iof), .o_io_data(iod), .o_io_data_oe(oe),
        .i_io_data(pio), .o_output_strobe(ostb), .o_input_strobe(istb),
        .i_sense(sense), .i_irq(irq));
    acx_periph i_acx_periph (.i_clk_sys(i_clk_sys), .i_io_addr(ioa),
        .i_io_func(iof), .i_io_data(iod), .i_io_data_oe(oe),
        .i_output_strobe(ostb), .i_input_strobe(istb), .o_io_data(pio),
        .o_sense(sense));
    initial forever #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
        if (mwe === 1'b1)
            mem[maddr[8:0]] <= mwd;
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge i_clk_sys);
        pen <= 1'b1;
        do @(posedge i_clk_sys); while (pready !== 1'b1);
        st = prd;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clk_sys);
    endtask : apb
    task automatic prog(input int a, input logic [15:0] p [8]);
        foreach (p[i]) mem[a+i] = p[i];
    endtask : prog
    task automatic run(input logic [14:0] pc);
        apb(1'b1, 12'h008, {17'h0, pc});
        apb(1'b1, 12'h000, 32'h1);
        st = 32'h40000;
        for (int i = 0; i < 100 && st[18] === 1'b1; i++)
            apb(1'b0, 12'h004, 32'h0);
        `CHK("halted", 1'b0, st[18]);
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, 12'h004, 32'h0);
        `CHK("status", 19'h20000, st[18:0]);
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped", 1'b1, err);
    endtask : t_reset
    task automatic t_arith;
        prog(0, '{16'h0100, 16'h3101, 16'h5102, 16'h6103, 16'h5104,
                  16'h7200, 16'h7200, 16'h7200});
        prog(9'h100, '{16'h7fff, 16'h1, 0, 16'hffff, 16'h1234, 0, 0, 0});
        run(0);
        `CHK("sum", 16'h8000, mem[9'h102]);
        `CHK("index", 16'h0, mem[9'h103]);
        `CHK("skip", 16'h1234, mem[9'h104]);
        `CHK("acc", 16'h0, st[15:0]);
    endtask : t_arith
    task automatic t_shift;
        // rotate, shift, bit test (bit 10 from top), negate
        prog(9'h40, '{16'h0140, 16'h7101, 16'h7004, 16'h750a, 16'h5141,
                      16'h7700, 16'h5142, 16'h7200});
        prog(9'h140, '{16'h8001, 0, 16'h5555, 0, 0, 0, 0, 0});
        run(15'h40);
        `CHK("bitskip", 16'h0, mem[9'h141]);
        `CHK("neg", 16'hffd0, mem[9'h142]);
    endtask : t_shift
    task automatic t_io;
        prog(9'h20, '{16'h0110, 16'h7835, 16'h7926, 16'h5111, 16'h7200,
                      16'h7200, 16'h7200, 16'h7200});
        prog(9'h110, '{16'ha5c3, 0, 0, 0, 0, 0, 0, 0});
        run(15'h20);
        `CHK("dout", 16'ha5c3, i_acx_periph.latched[3]);
        `CHK("din", 16'hd026, mem[9'h111]);
        `CHK("ioaddr", 8'h26, {ioa, iof});
    endtask : t_io
    task automatic t_jump;
        prog(9'h60, '{16'h0153, 16'h2150, 16'h7200, 16'h7200, 16'h7200,
                      16'h7200, 16'h7200, 16'h7200});
        prog(9'h150, '{16'h0160, 16'h1070, 16'h5555, 16'h7777, 0, 0, 0, 0});
        prog(9'h70, '{16'h5152, 16'h7200, 16'h7200, 16'h7200, 16'h7200,
                      16'h7200, 16'h7200, 16'h7200});
        run(15'h60);
        `CHK("link", 16'h0062, mem[9'h160]);
        `CHK("cleared", 16'h0, mem[9'h152]);
    endtask : t_jump
    task automatic t_irq;
        // request raised while masked, served after unmask, then returned
        prog(9'h80, '{16'h0170, 16'h7c00, 16'h7f00, 16'h7f00, 16'h5171,
                      16'h7200, 16'h7200, 16'h7200});
        prog(9'h10, '{16'h0172, 16'h5173, 16'h7a00, 16'h7200, 16'h7200,
                      16'h7200, 16'h7200, 16'h7200});
        prog(9'h170, '{16'h4321, 0, 16'h1111, 0, 0, 0, 0, 0});
        irq <= 4'h1;
        run(15'h80);
        `CHK("handler", 16'h1111, mem[9'h173]);
        `CHK("restored", 16'h4321, mem[9'h171]);
        `CHK("unmasked", 1'b0, st[17]);
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        foreach (mem[i]) mem[i] = 16'h0;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        t_reset;
        t_arith;
        t_shift;
        t_io;
        t_jump;
        t_irq;
        final_report;
    end
    // a few hundred clocks suffice; stop a hang at 12500 clocks
    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule : tb_acx_core
